// ### src/ext_io_pkg.sv
// Constants shared by the external control port of the pulsed laser welder
package ext_io_pkg;
   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ        = 200_000_000;
   localparam int unsigned PULSE_MS      = 40;            // Contact pulse length in ms
   localparam int unsigned DEBOUNCE_MS   = 5;             // Contact settle time in ms
   localparam int unsigned PULSE_CYC     = PULSE_MS * (CLK_HZ / 1000);
   localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int          CNT_W         = 24;
   // ==========================================================
   // Input and field layout
   localparam int          NUM_IN        = 11;            // Debounced contact inputs
   localparam int          IN_SEL3       = 0;
   localparam int          IN_SEL4       = 1;
   localparam int          IN_PROG_LSB   = 2;             // Weighted bits 2..6
   localparam int          IN_HV         = 7;
   localparam int          IN_CLEAR     = 8;
   localparam int          IN_TAKEOVER   = 9;
   localparam int          IN_SPARE      = 10;
   localparam int          PROG_W        = 5;
   // ==========================================================
   // Reset values of the contact outputs (1 = closed)
   localparam logic        FAULT_RST     = 1'b1;          // Fault contact closed when healthy
   localparam logic        LIMIT_RST     = 1'b1;          // Lamp limit contact normally closed
   localparam logic [4:0]  PROG_RST      = 5'h00;
endpackage

// ### src/contact_debounce.sv
// Synchroniser and debounce filter for one contact input
`timescale 1ns/1ps
module contact_debounce
   import ext_io_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic raw_in,
   output logic      clean_q,
   output logic      stable_q
);
   logic             sync1_q;
   logic             sync2_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             clean_d;
   logic             stable_d;

   // ==========================================================
   // Filter: accept a new level after it holds for the settle time
   always_comb begin
      cnt_d    = cnt_q;
      clean_d  = clean_q;
      stable_d = 1'b1;
      if (sync2_q == clean_q) begin
         cnt_d = '0;
      end else begin
         stable_d = 1'b0;
         if (cnt_q >= CNT_W'(DEBOUNCE_CYC - 1)) begin
            clean_d = sync2_q;
            cnt_d   = '0;
         end else begin
            cnt_d = cnt_q + CNT_W'(1);
         end
      end
   end

   // Two-flop synchroniser then filter state
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_q  <= 1'b0;
         sync2_q  <= 1'b0;
         cnt_q    <= '0;
         clean_q  <= 1'b0;
         stable_q <= 1'b1;
      end else begin
         sync1_q  <= raw_in;
         sync2_q  <= sync1_q;
         cnt_q    <= cnt_d;
         clean_q  <= clean_d;
         stable_q <= stable_d;
      end
   end
endmodule

// ### src/contact_pulse.sv
// Fixed-length contact pulse generator, retriggerable
`timescale 1ns/1ps
module contact_pulse
   import ext_io_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic trig,
   output logic      pulse_q
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             pulse_d;

   // Load on trigger, count down, contact closed while nonzero
   always_comb begin
      cnt_d = cnt_q;
      if (trig) begin
         cnt_d = CNT_W'(PULSE_CYC);
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - CNT_W'(1);
      end
      pulse_d = (cnt_d != '0);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q   <= '0;
         pulse_q <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         pulse_q <= pulse_d;
      end
   end
endmodule

// ### src/laser_external_io_port.sv
// External discrete control port: input decode and status contact outputs
`timescale 1ns/1ps
// How it works
// RULE1: select three held selects beam path three
// RULE2: select four held selects beam path four
// RULE3: five weighted inputs decode to index 0-31
// RULE4: ready closes when high voltage and charged
// RULE5: high-voltage contact follows supply active state
// RULE6: fault contact opens, stays open until cleared
// RULE7: flash-complete contact closes 40 ms per flash
// RULE8: energy-pass contact closes 40 ms within limits
// RULE9: energy-fail contact closes 40 ms outside limits
// RULE10: accepted contact follows takeover input
// RULE11: inputs ignored while accepted contact open
// RULE12: lamp limit opens above reference power
// RULE13: external inputs effective only under takeover
// RULE14: clear input cancels fault once cause gone
// RULE15: high voltage follows request input level
// RULE16: inputs debounced; index sampled when stable
module laser_external_io_port
   import ext_io_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              beam_sel3_in,
   input  wire logic              beam_sel4_in,
   input  wire logic [PROG_W-1:0] prog_bits_in,
   input  wire logic              hv_request,
   input  wire logic              fault_clear_in,
   input  wire logic              external_takeover,
   input  wire logic              hv_active,
   input  wire logic              cap_charged,
   input  wire logic              fault_event,
   input  wire logic              fault_cause,
   input  wire logic              flash_done,
   input  wire logic              energy_valid,
   input  wire logic [15:0]       energy_value,
   input  wire logic [15:0]       energy_high,
   input  wire logic [15:0]       energy_low,
   input  wire logic [15:0]       lamp_power,
   input  wire logic [15:0]       lamp_power_ref,
   output logic                   path3_select_q,
   output logic                   path4_select_q,
   output logic [PROG_W-1:0]      program_index_q,
   output logic                   hv_enable_q,
   output logic                   ready_q,
   output logic                   hv_present_q,
   output logic                   fault_ok_q,
   output logic                   flash_end_q,
   output logic                   energy_pass_q,
   output logic                   energy_fail_q,
   output logic                   inputs_accepted_q,
   output logic                   lamp_ok_q
);
   // ==========================================================
   // Input conditioning
   logic [NUM_IN-1:0] raw;
   logic [NUM_IN-1:0] clean;
   logic [NUM_IN-1:0] stable;

   assign raw = {1'b0, external_takeover, fault_clear_in, hv_request,
                 prog_bits_in, beam_sel4_in, beam_sel3_in};

   // One debouncer per contact input
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_db
         contact_debounce u_db (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .raw_in   (raw[gi]),
            .clean_q  (clean[gi]),
            .stable_q (stable[gi])
         ); // RULE16
      end
   endgenerate

   // Range check used by both monitor contacts
   function automatic logic in_range(input logic [15:0] v, input logic [15:0] hi,
                                     input logic [15:0] lo);
      in_range = (v <= hi) && (v >= lo);
   endfunction

   // ==========================================================
   // Control decode
   logic              accept;
   logic              prog_stable;
   logic              path3_d;
   logic              path4_d;
   logic [PROG_W-1:0] prog_d;
   logic              hv_en_d;
   logic              ready_d;
   logic              hvp_d;
   logic              fault_d;
   logic              acc_d;
   logic              lamp_d;

   assign accept      = clean[IN_TAKEOVER];
   assign prog_stable = &stable[IN_PROG_LSB +: PROG_W];

   // Next values of the level contacts and decoded selections
   always_comb begin
      acc_d   = accept; // RULE10
      path3_d = accept && clean[IN_SEL3]; // RULE1 RULE11 RULE13
      path4_d = accept && clean[IN_SEL4]; // RULE2 RULE11 RULE13
      prog_d  = program_index_q;
      if (accept && prog_stable) begin
         prog_d = clean[IN_PROG_LSB +: PROG_W]; // RULE3 RULE16
      end
      hv_en_d = hv_enable_q;
      if (accept) begin
         hv_en_d = clean[IN_HV]; // RULE15
      end
      hvp_d   = hv_active; // RULE5
      ready_d = hv_active && cap_charged; // RULE4
      fault_d = fault_ok_q;
      if (fault_event) begin
         fault_d = 1'b0; // RULE6
      end else if (accept && clean[IN_CLEAR] && !fault_cause) begin
         fault_d = 1'b1; // RULE14
      end
      lamp_d = !(lamp_power > lamp_power_ref); // RULE12
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         inputs_accepted_q <= 1'b0;
         path3_select_q    <= 1'b0;
         path4_select_q    <= 1'b0;
         program_index_q   <= PROG_RST;
         hv_enable_q       <= 1'b0;
         hv_present_q      <= 1'b0;
         ready_q           <= 1'b0;
         fault_ok_q        <= FAULT_RST;
         lamp_ok_q         <= LIMIT_RST;
      end else begin
         inputs_accepted_q <= acc_d;
         path3_select_q    <= path3_d;
         path4_select_q    <= path4_d;
         program_index_q   <= prog_d;
         hv_enable_q       <= hv_en_d;
         hv_present_q      <= hvp_d;
         ready_q           <= ready_d;
         fault_ok_q        <= fault_d;
         lamp_ok_q         <= lamp_d;
      end
   end

   // ==========================================================
   // Pulse contacts
   logic pass_trig;
   logic fail_trig;

   assign pass_trig = energy_valid && in_range(energy_value, energy_high, energy_low);
   assign fail_trig = energy_valid && !in_range(energy_value, energy_high, energy_low);

   contact_pulse u_end (
      .ref_clk (ref_clk),
      .rst     (rst),
      .trig    (flash_done),
      .pulse_q (flash_end_q)
   ); // RULE7

   contact_pulse u_pass (
      .ref_clk (ref_clk),
      .rst     (rst),
      .trig    (pass_trig),
      .pulse_q (energy_pass_q)
   ); // RULE8

   contact_pulse u_fail (
      .ref_clk (ref_clk),
      .rst     (rst),
      .trig    (fail_trig),
      .pulse_q (energy_fail_q)
   ); // RULE9

   // ==========================================================
   // Checks
   // First edge after reset still shows the reset value, so skip it
   a_ready_follows: assert property (@(posedge ref_clk) disable iff (rst)
      !$past(rst) |-> ready_q == $past(hv_active && cap_charged)) // RULE4
      else $error("ready contact wrong");
   a_hv_present: assert property (@(posedge ref_clk) disable iff (rst)
      !$past(rst) |-> hv_present_q == $past(hv_active)) // RULE5
      else $error("high voltage contact wrong");
   a_fault_opens: assert property (@(posedge ref_clk) disable iff (rst)
      fault_event |=> !fault_ok_q) // RULE6
      else $error("fault contact did not open");
   a_fault_holds: assert property (@(posedge ref_clk) disable iff (rst)
      (!fault_ok_q && !(accept && clean[IN_CLEAR])) |=> !fault_ok_q) // RULE14
      else $error("fault released without clear");
   a_flash_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(flash_done) |=> flash_end_q[*8]) // RULE7
      else $error("flash end pulse too short");
   a_pass_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      pass_trig |=> energy_pass_q) // RULE8
      else $error("energy pass pulse missing");
   a_fail_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      fail_trig |=> energy_fail_q) // RULE9
      else $error("energy fail pulse missing");
   a_accept_follows: assert property (@(posedge ref_clk) disable iff (rst)
      !$past(rst) |-> inputs_accepted_q == $past(accept)) // RULE10
      else $error("accepted contact wrong");
   a_ignore_inputs: assert property (@(posedge ref_clk) disable iff (rst)
      !accept |=> !path3_select_q && !path4_select_q
                  && $stable(program_index_q) && $stable(hv_enable_q)) // RULE11
      else $error("input acted without takeover");
   a_lamp_limit: assert property (@(posedge ref_clk) disable iff (rst)
      (lamp_power > lamp_power_ref) |=> !lamp_ok_q) // RULE12
      else $error("lamp limit contact did not open");
   a_path3_sel: assert property (@(posedge ref_clk) disable iff (rst)
      (accept && clean[IN_SEL3]) |=> path3_select_q) // RULE1
      else $error("path three not selected");
   a_path4_sel: assert property (@(posedge ref_clk) disable iff (rst)
      (accept && clean[IN_SEL4]) |=> path4_select_q) // RULE2
      else $error("path four not selected");
   a_prog_decode: assert property (@(posedge ref_clk) disable iff (rst)
      (accept && prog_stable) |=> program_index_q == $past(clean[IN_PROG_LSB +: PROG_W]))
      // RULE3
      else $error("program index wrong");
   a_hv_request: assert property (@(posedge ref_clk) disable iff (rst)
      accept |=> hv_enable_q == $past(clean[IN_HV])) // RULE15
      else $error("high voltage enable wrong");
endmodule

// ### tb/ext_controller.sv
// Behavioural machine controller that drives the contact inputs of the port
`timescale 1ns/1ps
module ext_controller (
   input  wire logic [31:0] word,
   input  wire logic        cause_gone,
   output logic             sel3,
   output logic             sel4,
   output logic [4:0]       prog,
   output logic             hv_req,
   output logic             clr,
   output logic             takeover
);
   // ==========================================================
   // Contact levels, closed contact is a one
   assign sel3 = word[20];
   assign sel4 = word[21];
   assign hv_req = word[22];
   assign prog = word[28:24];
   // Clear is only closed once the fault cause is gone
   assign clr = word[23] & cause_gone;
   // Takeover contact gates every other contact
   assign takeover = word[29];
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the external control port
`timescale 1ns/1ps
module tb_top;
   import ext_io_pkg::*;
   // ==========================================================
   // Stimulus and observed signals
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        hv_active = 1'b0, cap_charged = 1'b0, fault_event = 1'b0;
   logic        fault_cause = 1'b0, flash_done = 1'b0, energy_valid = 1'b0;
   logic [15:0] energy_value = 16'h0000, lamp_power = 16'h0000;
   logic [31:0] seed = 32'hC36FA279;
   logic        sel3, sel4, hv_req, clr, takeover;
   logic [4:0]  prog, pidx;
   logic        p3, p4, hv_en, rdy, hvp, f_ok, f_end, e_ok, e_bad, acc, l_ok;
   logic        x_rdy, x_hvp, x_fok, x_end, x_ok, x_bad, x_lok;
   int          err_count = 0;
   int          n_tests = 0;

   always #2.5 ref_clk = ~ref_clk;

   ext_controller ctl (.word(seed), .cause_gone(~fault_cause), .sel3(sel3), .sel4(sel4),
      .prog(prog), .hv_req(hv_req), .clr(clr), .takeover(takeover));

   laser_external_io_port dut (.ref_clk(ref_clk), .rst(rst), .beam_sel3_in(sel3),
      .beam_sel4_in(sel4), .prog_bits_in(prog), .hv_request(hv_req), .fault_clear_in(clr),
      .external_takeover(takeover), .hv_active(hv_active), .cap_charged(cap_charged),
      .fault_event(fault_event), .fault_cause(fault_cause), .flash_done(flash_done),
      .energy_valid(energy_valid), .energy_value(energy_value), .energy_high(16'h2000),
      .energy_low(16'h1000), .lamp_power(lamp_power), .lamp_power_ref(16'h8000),
      .path3_select_q(p3), .path4_select_q(p4), .program_index_q(pidx),
      .hv_enable_q(hv_en), .ready_q(rdy), .hv_present_q(hvp), .fault_ok_q(f_ok),
      .flash_end_q(f_end), .energy_pass_q(e_ok), .energy_fail_q(e_bad),
      .inputs_accepted_q(acc), .lamp_ok_q(l_ok));

   // ==========================================================
   // Random source and compare tasks
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_idx(input logic [4:0] got, input logic [4:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ==========================================================
   // Reference model, one rising edge per call
   task automatic model_step();
      x_rdy = hv_active & cap_charged;
      x_hvp = hv_active;
      x_lok = (lamp_power <= 16'h8000);
      if (fault_event) x_fok = 1'b0;
      if (flash_done) x_end = 1'b1;
      if (energy_valid && energy_value >= 16'h1000 && energy_value <= 16'h2000) x_ok = 1'b1;
      if (energy_valid && (energy_value < 16'h1000 || energy_value > 16'h2000)) x_bad = 1'b1;
   endtask

   // Contacts never settle for the debounce time, so their outputs stay idle
   task automatic check_all();
      chk_bit(rdy, x_rdy);
      chk_bit(hvp, x_hvp);
      chk_bit(f_ok, x_fok);
      chk_bit(f_end, x_end);
      chk_bit(e_ok, x_ok);
      chk_bit(e_bad, x_bad);
      chk_bit(acc, 1'b0);
      chk_bit(l_ok, x_lok);
      chk_bit(p3, 1'b0);
      chk_bit(p4, 1'b0);
      chk_bit(hv_en, 1'b0);
      chk_idx(pidx, 5'h00);
   endtask

   // New random inputs, rare events from six-bit matches
   task automatic drive_next();
      seed = xs(seed);
      hv_active = seed[0];
      cap_charged = seed[1];
      fault_cause = seed[2];
      fault_event = (seed[7:2] == 6'h3F);
      flash_done = (seed[13:8] == 6'h00);
      energy_valid = (seed[19:14] == 6'h00);
      energy_value = 16'h0F00 + 16'(seed[31:19]);
      lamp_power = seed[31:16];
      model_step();
   endtask

   // Reset held four cycles, outputs at their reset values meanwhile
   task automatic do_reset();
      rst = 1'b1;
      {x_rdy, x_hvp, x_end, x_ok, x_bad} = 5'h00;
      x_fok = 1'b1;
      x_lok = 1'b1;
      repeat (4) begin
         @(negedge ref_clk);
         check_all();
      end
      rst = 1'b0;
      model_step();
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Three runs, each begun by a reset, the second and third in mid-traffic
   initial begin
      for (int s = 0; s < 3; s++) begin
         do_reset();
         for (int c = 0; c < 5000; c++) begin
            @(negedge ref_clk);
            check_all();
            drive_next();
         end
      end
      complete_run();
   end
endmodule
